// ---- smt_defs.vh ----
// Register map, field layout and timing constants of the serial master
`ifndef SMT_DEFS_VH
`define SMT_DEFS_VH

// Register byte offsets
`define SMT_REG_CTRL 5'h00
`define SMT_REG_CTRL1 5'h04
`define SMT_REG_DIV 5'h08
`define SMT_REG_SEL 5'h0C
`define SMT_REG_DLY 5'h10
`define SMT_REG_DATA 5'h14
`define SMT_REG_STATUS 5'h18
`define SMT_REG_THRESH 5'h1C
`define SMT_ADDR_W 5

// Control fields
`define SMT_CTRL_EN 0
`define SMT_CTRL_MODE_LO 1
`define SMT_CTRL_MODE_HI 2
`define SMT_CTRL_CPOL 3
`define SMT_CTRL_CPHA 4
`define SMT_CTRL_FMT 5
`define SMT_CTRL_DMAE 6

// Transfer modes
`define SMT_MODE_TXRX 2'h0
`define SMT_MODE_TX 2'h1
`define SMT_MODE_RX 2'h2
`define SMT_MODE_EE 2'h3

// Status bits
`define SMT_ST_BUSY 0
`define SMT_ST_TFE 1
`define SMT_ST_TFNF 2
`define SMT_ST_RFNE 3
`define SMT_ST_RFF 4
`define SMT_ST_RXO 5
`define SMT_ST_TXE 6
`define SMT_ST_DMATX 7

// Sizes
`define SMT_FRAME_W 8
`define SMT_FIFO_DEPTH 16
`define SMT_LVL_W 5
`define SMT_NDF_W 16
`define SMT_DIV_W 16
`define SMT_DLY_W 8

// Reset values
`define SMT_DIV_RST 16'h0002

`endif

// ---- smt_fifo.v ----
// Small synchronous FIFO used for the transmit and receive queues
`timescale 1ns/1ns
module smt_fifo (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Write side
    input wire wr_i,
    input wire [7:0] wdata_i,
    // Read side
    input wire rd_i,
    output wire [7:0] rdata_o,
    // Status
    output wire empty_o,
    output wire full_o,
    output wire [4:0] level_o
);
    reg [7:0] mem [0:15];
    reg [3:0] wptr;
    reg [3:0] rptr;
    reg [4:0] level;
    wire do_wr = wr_i && (level != 5'h10);
    wire do_rd = rd_i && (level != 5'h00);

    assign rdata_o = mem[rptr];
    assign empty_o = (level == 5'h00);
    assign full_o = (level == 5'h10);
    assign level_o = level;

    always @(posedge clk_i) begin
        if (do_wr) begin
            mem[wptr] <= wdata_i;
        end
        if (rst_i) begin
            wptr <= 4'h0;
            rptr <= 4'h0;
            level <= 5'h00;
        end else begin
            if (do_wr) begin
                wptr <= wptr + 4'h1;
            end
            if (do_rd) begin
                rptr <= rptr + 4'h1;
            end
            if (do_wr && !do_rd) begin
                level <= level + 5'h01;
            end else if (do_rd && !do_wr) begin
                level <= level - 5'h01;
            end
        end
    end
endmodule

// ---- smt_master.v ----
// Serial master shift control with transfer modes and Wishbone registers
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
`include "smt_defs.vh"

// How it works
// - Receive-only mode holds data output constant
// - Receive-only never pops transmit queue as slave
// - Receive-only stores every completed frame that the receive queue has room for
// - EEPROM read only exists as master
// - EEPROM read ignores input while sending
// - EEPROM read sends until empty, then receives
// - Receive modes stop after count plus one
// - EEPROM read refused under sync serial format
// - Master generates and drives serial clock
// - Disabled means no transfer, clock idle
// - Receive sample delay in core cycles
// - Start needs enable, data and slave select
// - Busy set only once shifting is under way
// - Shifting starts on next serial clock rise
// - Transmit modes stop when queue empties
// - Threshold and DMA transmit requests
// - Receive-only pops the dummy word once
// - Transmit-only discards received frames
// - Full receive queue drops frame, flags overflow
module smt_master (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Serial pins
    output reg sclk_o,
    output reg mosi_o,
    output reg [3:0] ss_n_o,
    input wire miso_i,
    // Status outputs
    output reg busy_o,
    output reg tx_thresh_o,
    output reg dma_tx_req_o,
    output reg rx_overflow_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_SHIFT = 2'h2;
    localparam ST_END = 2'h3;

    // Registers
    reg [6:0] ctrl;
    reg [15:0] frame_count_field;
    reg [15:0] div;
    reg [3:0] sel;
    reg [7:0] dly;
    reg [3:0] txftl;
    reg [3:0] dmatdl;
    reg rxo;

    // Shift engine
    reg [1:0] state;
    reg [15:0] div_cnt;
    reg sclk_int;
    reg [7:0] tx_sr;
    reg [7:0] rx_sr;
    reg [3:0] bit_cnt;
    reg [15:0] rx_frames;
    reg tx_phase;
    reg miso_s1;
    reg miso_s2;
    reg [7:0] sample_cnt;
    reg sample_pend;
    reg frame_done;

    wire en = ctrl[`SMT_CTRL_EN];
    wire [1:0] mode = ctrl[`SMT_CTRL_MODE_HI:`SMT_CTRL_MODE_LO];
    wire cpol = ctrl[`SMT_CTRL_CPOL];
    wire fmt_sync = ctrl[`SMT_CTRL_FMT];
    wire acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Writes land on the edge where the master sees ack, while it still holds the request
    wire wr_acc = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    wire rd_acc = acc && !wb_we_i;

    wire tx_empty;
    wire tx_full;
    wire [4:0] tx_level;
    wire [7:0] tx_head;
    wire rx_empty;
    wire rx_full;
    wire [4:0] rx_level;
    wire [7:0] rx_head;
    reg tx_pop;
    reg rx_push;

    // Clock divider: tick on each half period
    wire half_tick = (div_cnt == 16'h0001) || (div_cnt == 16'h0000);
    wire rise_tick = half_tick && !sclk_int;
    wire fall_tick = half_tick && sclk_int;

    // Receive modes store input; EEPROM read only after the send phase
    function rx_store;
        input [1:0] m;
        input tx_ph;
        begin
            rx_store = (m == `SMT_MODE_TXRX) || (m == `SMT_MODE_RX) ||
                ((m == `SMT_MODE_EE) && !tx_ph);
        end
    endfunction

    wire tx_push = wr_acc && (wb_adr_i == `SMT_REG_DATA);
    wire rx_pop = rd_acc && (wb_adr_i == `SMT_REG_DATA);

    smt_fifo u_tx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(tx_push),
        .wdata_i(wb_dat_i[7:0]),
        .rd_i(tx_pop),
        .rdata_o(tx_head),
        .empty_o(tx_empty),
        .full_o(tx_full),
        .level_o(tx_level)
    );

    smt_fifo u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(rx_push),
        .wdata_i(rx_sr),
        .rd_i(rx_pop),
        .rdata_o(rx_head),
        .empty_o(rx_empty),
        .full_o(rx_full),
        .level_o(rx_level)
    );

    // Register bus: one single-cycle ack per request, registered one cycle after it
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl <= 7'h00;
            frame_count_field <= 16'h0000;
            div <= `SMT_DIV_RST;
            sel <= 4'h0;
            dly <= 8'h00;
            txftl <= 4'h0;
            dmatdl <= 4'h0;
        end else begin
            wb_ack_o <= acc;
            if (wr_acc) begin
                case (wb_adr_i)
                    `SMT_REG_CTRL: begin
                        ctrl <= wb_dat_i[6:0];
                        // EEPROM read under sync format falls back to receive-only
                        if (wb_dat_i[`SMT_CTRL_FMT] && wb_dat_i[2:1] == `SMT_MODE_EE) begin
                            ctrl[`SMT_CTRL_MODE_HI:`SMT_CTRL_MODE_LO] <= `SMT_MODE_RX;
                        end
                    end
                    `SMT_REG_CTRL1: frame_count_field <= wb_dat_i[15:0];
                    `SMT_REG_DIV: div <= (wb_dat_i[15:0] < 16'h0002) ? 16'h0002 : wb_dat_i[15:0];
                    `SMT_REG_SEL: sel <= wb_dat_i[3:0];
                    `SMT_REG_DLY: dly <= wb_dat_i[7:0];
                    `SMT_REG_THRESH: begin
                        txftl <= wb_dat_i[3:0];
                        dmatdl <= wb_dat_i[11:8];
                    end
                    default: ;
                endcase
            end
            if (rd_acc) begin
                case (wb_adr_i)
                    `SMT_REG_CTRL: wb_dat_o <= {25'h0, ctrl};
                    `SMT_REG_CTRL1: wb_dat_o <= {16'h0, frame_count_field};
                    `SMT_REG_DIV: wb_dat_o <= {16'h0, div};
                    `SMT_REG_SEL: wb_dat_o <= {28'h0, sel};
                    `SMT_REG_DLY: wb_dat_o <= {24'h0, dly};
                    `SMT_REG_DATA: wb_dat_o <= rx_empty ? 32'h0 : {24'h0, rx_head};
                    `SMT_REG_STATUS: wb_dat_o <= {24'h0, dma_tx_req_o, tx_thresh_o, rxo, rx_full,
                        !rx_empty, !tx_full, tx_empty, busy_o};
                    `SMT_REG_THRESH: wb_dat_o <= {20'h0, dmatdl, 4'h0, txftl};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Shift engine
    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            div_cnt <= 16'h0000;
            sclk_int <= 1'b0;
            sclk_o <= 1'b0;
            mosi_o <= 1'b0;
            ss_n_o <= 4'hF;
            busy_o <= 1'b0;
            tx_sr <= 8'h00;
            rx_sr <= 8'h00;
            bit_cnt <= 4'h0;
            rx_frames <= 16'h0000;
            tx_phase <= 1'b0;
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
            sample_cnt <= 8'h00;
            sample_pend <= 1'b0;
            frame_done <= 1'b0;
            tx_pop <= 1'b0;
            rx_push <= 1'b0;
            rxo <= 1'b0;
            rx_overflow_o <= 1'b0;
            tx_thresh_o <= 1'b0;
            dma_tx_req_o <= 1'b0;
        end else begin
            miso_s1 <= miso_i;
            miso_s2 <= miso_s1;
            tx_pop <= 1'b0;
            rx_push <= 1'b0;
            frame_done <= 1'b0;
            tx_thresh_o <= en && (tx_level <= {1'b0, txftl});
            dma_tx_req_o <= en && ctrl[`SMT_CTRL_DMAE] && (tx_level <= {1'b0, dmatdl});
            // Clear first so that an overflow in the same cycle wins
            if (rd_acc && wb_adr_i == `SMT_REG_STATUS) begin
                rxo <= 1'b0;
                rx_overflow_o <= 1'b0;
            end
            // Generated clock only runs while a transfer is under way
            if (state == ST_IDLE || !en) begin
                div_cnt <= div >> 1;
                sclk_int <= 1'b0;
            end else if (half_tick) begin
                div_cnt <= div >> 1;
                sclk_int <= !sclk_int;
            end else begin
                div_cnt <= div_cnt - 16'h0001;
            end
            sclk_o <= (state == ST_SHIFT) ? (sclk_int ^ cpol) : cpol;
            // Sample point delayed by programmed core cycles
            // The first rise comes while still waiting and carries the first bit
            if ((state == ST_WAIT || state == ST_SHIFT) && rise_tick) begin
                sample_cnt <= dly;
                sample_pend <= 1'b1;
            end else if (sample_pend) begin
                if (sample_cnt == 8'h00) begin
                    sample_pend <= 1'b0;
                    rx_sr <= {rx_sr[6:0], miso_s2};
                    if (bit_cnt == 4'h0) begin
                        frame_done <= 1'b1;
                    end
                end else begin
                    sample_cnt <= sample_cnt - 8'h01;
                end
            end
            // End of frame: store or drop received word
            if (frame_done) begin
                if (rx_store(mode, tx_phase)) begin
                    rx_frames <= rx_frames + 16'h0001;
                    if (rx_full) begin
                        rxo <= 1'b1;
                        rx_overflow_o <= 1'b1;
                    end else begin
                        rx_push <= 1'b1;
                    end
                end
            end
            if (!en) begin
                state <= ST_IDLE;
                ss_n_o <= 4'hF;
                busy_o <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (!tx_empty && sel != 4'h0) begin
                            state <= ST_WAIT;
                            tx_sr <= tx_head;
                            tx_pop <= 1'b1;
                            tx_phase <= (mode == `SMT_MODE_EE);
                            rx_frames <= 16'h0000;
                            bit_cnt <= 4'h7;
                            ss_n_o <= ~sel;
                        end
                    end
                    ST_WAIT: begin
                        if (rise_tick) begin
                            state <= ST_SHIFT;
                            busy_o <= 1'b1;
                            mosi_o <= (mode == `SMT_MODE_RX) ? 1'b0 : tx_sr[7];
                        end
                    end
                    ST_SHIFT: begin
                        if (fall_tick) begin
                            if (bit_cnt != 4'h0) begin
                                bit_cnt <= bit_cnt - 4'h1;
                                tx_sr <= {tx_sr[6:0], 1'b0};
                                mosi_o <= (mode == `SMT_MODE_RX || !tx_phase && mode == `SMT_MODE_EE) ?
                                    1'b0 : tx_sr[6];
                            end else begin
                                bit_cnt <= 4'h7;
                                if (mode == `SMT_MODE_RX || (mode == `SMT_MODE_EE && !tx_phase)) begin
                                    mosi_o <= 1'b0;
                                    // Count already holds the frame just closed
                                    if (rx_frames == frame_count_field + 16'h0001 &&
                                        !sample_pend) begin
                                        state <= ST_END;
                                    end
                                end else if (!tx_empty) begin
                                    // Head kept whole: the next fall sends its bit 6
                                    tx_sr <= tx_head;
                                    mosi_o <= tx_head[7];
                                    tx_pop <= 1'b1;
                                end else if (mode == `SMT_MODE_EE) begin
                                    tx_phase <= 1'b0;
                                    mosi_o <= 1'b0;
                                end else begin
                                    state <= ST_END;
                                end
                            end
                        end
                    end
                    ST_END: begin
                        // Busy drops only once the pin clock is back at its idle level
                        if (!sample_pend && !frame_done && sclk_o == cpol) begin
                            state <= ST_IDLE;
                            busy_o <= 1'b0;
                            ss_n_o <= 4'hF;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ---- smt_monitor.sv ----
// Checker for the serial master's bus answer and serial pin timing
`timescale 1ns/1ns
module smt_monitor (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [4:0] wb_adr_i,
    input wire wb_we_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Serial and status
    input wire sclk_o,
    input wire mosi_o,
    input wire [3:0] ss_n_o,
    input wire busy_o,
    input wire rx_overflow_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack;
        s_req |=> s_ans;
    endproperty
    property p_hi;
        wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000;
    endproperty
    property p_busy_sel;
        busy_o |-> ss_n_o != 4'hF;
    endproperty
    property p_busy_rise;
        $rose(busy_o) |=> $changed(sclk_o);
    endproperty
    property p_sel_hold;
        busy_o && $past(busy_o) |-> $stable(ss_n_o);
    endproperty
    // Data moves one core cycle ahead of a clock edge, never between edges
    property p_mosi;
        $changed(mosi_o) && $stable(ss_n_o) |=> $changed(sclk_o);
    endproperty
    // Status read is the only way out of overflow
    property p_ovf;
        rx_overflow_o && !(wb_stb_i && wb_adr_i == 5'h18) |=> rx_overflow_o;
    endproperty
    property p_end;
        $fell(busy_o) |-> $stable(sclk_o)[*2];
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    a_hi: assert property (p_hi) else $error("upper read bits not zero");
    a_busy_sel: assert property (p_busy_sel) else $error("busy without slave select");
    a_busy_rise: assert property (p_busy_rise) else $error("busy rose off a clock edge");
    a_sel_hold: assert property (p_sel_hold) else $error("select moved while busy");
    a_mosi: assert property (p_mosi) else $error("data out moved without clock");
    a_ovf: assert property (p_ovf) else $error("overflow dropped early");
    a_end: assert property (p_end) else $error("busy fell while clock moving");
endmodule

bind smt_master smt_monitor smt_monitor_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sclk_o(sclk_o), .mosi_o(mosi_o), .ss_n_o(ss_n_o), .busy_o(busy_o), .rx_overflow_o(rx_overflow_o));

// ---- smt_slave_model.sv ----
// Behavioural serial slave: replies one byte per frame, logs what it hears
`timescale 1ns/1ns
module smt_slave_model (
    // Serial pins
    input wire sclk_i,
    input wire mosi_i,
    input wire ss_n_i,
    output reg miso_o,
    // Observation
    output reg [7:0] got_o,
    output reg [7:0] seen_o,
    output reg [7:0] frames_o
);
    reg [7:0] tx;
    reg [7:0] sh;
    reg [2:0] n;
    initial begin
        miso_o = 1'b0;
        got_o = 8'h00;
        seen_o = 8'h00;
        frames_o = 8'h00;
        n = 3'd0;
        tx = 8'hC3;
        sh = 8'h00;
    end
    always @(negedge ss_n_i) begin
        n = 3'd0;
        tx = 8'hC3;
        sh = 8'h00;
        frames_o = 8'h00;
        seen_o = 8'h00;
        miso_o = tx[7];
    end
    // No pull on the line: released means a changed level
    always @(posedge ss_n_i) miso_o = ~miso_o;
    always @(posedge sclk_i) if (!ss_n_i) begin
        #1;
        sh = {sh[6:0], mosi_i};
        seen_o = seen_o | sh;
        n = n + 3'd1;
        if (n == 3'd0) begin
            got_o = sh;
            frames_o = frames_o + 8'h01;
        end
    end
    always @(negedge sclk_i) if (!ss_n_i) begin
        if (n == 3'd0) tx = tx + 8'h01;
        miso_o = tx[3'd7 - n];
    end
endmodule

// ---- smt_master_bench.sv ----
// Register-level tests of every transfer mode of the serial master
`timescale 1ns/1ns
module smt_master_bench;
`define CHK(n, e, v) begin check_count = check_count + 1; if ((v) !== (e)) begin \
    n_fail = n_fail + 1; $display("BAD %s exp %h got %h", n, e, v); end end
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [4:0] adr = 5'h00;
    reg [3:0] sel = 4'hF;
    reg [31:0] dat = 32'h00000000;
    reg [31:0] q;
    wire [31:0] rdat;
    wire ack, sclk, mosi, miso, busy, thr, dreq, ovf;
    wire [3:0] ss_n;
    wire [7:0] got, seen, frames;
    integer n_fail = 0;
    integer check_count = 0;
    integer ticks = 0;
    integer i;
    smt_master smt_master_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .sclk_o(sclk),
        .mosi_o(mosi), .ss_n_o(ss_n), .miso_i(miso), .busy_o(busy), .tx_thresh_o(thr),
        .dma_tx_req_o(dreq), .rx_overflow_o(ovf));
    smt_slave_model smt_slave_model_inst (.sclk_i(sclk), .mosi_i(mosi), .ss_n_i(ss_n[0]), .miso_o(miso),
        .got_o(got), .seen_o(seen), .frames_o(frames));
    always #2 clk_i = ~clk_i;
    task close_out;
        begin
            $display("checks %0d failures %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    always @(posedge clk_i) begin
        ticks = ticks + 1;
        if (ticks == 20000) begin
            n_fail = n_fail + 1;
            close_out;
        end
    end
    task wb(input w, input [4:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat <= d;
            t = 0;
            @(posedge clk_i);
            while (ack !== 1'b1 && t < 50) begin
                @(posedge clk_i);
                t = t + 1;
            end
            if (t == 50) n_fail = n_fail + 1;
            q = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    // Waits for busy to appear, then to clear
    task done;
        integer t;
        begin
            t = 0;
            while (busy !== 1'b1 && t < 400) begin
                @(posedge clk_i);
                t = t + 1;
            end
            `CHK("busy set", 1'b1, busy)
            while (busy !== 1'b0 && t < 9000) begin
                @(posedge clk_i);
                t = t + 1;
            end
            `CHK("end select", 4'hF, ss_n)
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 5'h08, 0);
        `CHK("div reset", 32'h00000002, q)
        wb(0, 5'h18, 0);
        `CHK("status reset", 4'h6, q[3:0])
        wb(0, 5'h01, 0);
        `CHK("unmapped", 32'h00000000, q)
        wb(1, 5'h10, 32'h2);
        sel <= 4'hE;
        wb(1, 5'h10, 32'h7);
        sel <= 4'hF;
        wb(0, 5'h10, 0);
        `CHK("delay", 32'h00000002, q)
        wb(1, 5'h08, 32'h14);
        wb(1, 5'h0C, 32'h0);
        wb(1, 5'h00, 32'h1);
        wb(1, 5'h14, 32'hA5);
        wb(1, 5'h14, 32'h3C);
        repeat (40) @(posedge clk_i);
        `CHK("unselected busy", 1'b0, busy)
        `CHK("unselected ss", 4'hF, ss_n)
        wb(1, 5'h0C, 32'h1);
        done;
        `CHK("txrx frames", 8'h02, frames)
        `CHK("txrx out", 8'h3C, got)
        for (i = 0; i < 2; i = i + 1) begin
            wb(0, 5'h14, 0);
            `CHK("txrx in", 32'hC3 + i, q)
        end
        wb(1, 5'h00, 32'h3);
        wb(1, 5'h14, 32'h5A);
        done;
        `CHK("tx out", 8'h5A, got)
        wb(0, 5'h18, 0);
        `CHK("tx no store", 1'b0, q[3])
        wb(1, 5'h10, 32'h5);
        wb(1, 5'h04, 32'h2);
        wb(1, 5'h00, 32'h5);
        wb(1, 5'h14, 32'hFF);
        done;
        `CHK("rx frames", 8'h03, frames)
        `CHK("rx out quiet", 8'h00, seen)
        for (i = 0; i < 3; i = i + 1) begin
            wb(0, 5'h14, 0);
            `CHK("rx in", 32'hC3 + i, q)
        end
        wb(0, 5'h18, 0);
        `CHK("rx status", 3'b011, q[3:1])
        wb(1, 5'h04, 32'h1);
        wb(1, 5'h00, 32'h7);
        for (i = 0; i < 3; i = i + 1) wb(1, 5'h14, 32'h3 + i);
        done;
        `CHK("ee frames", 8'h05, frames)
        `CHK("ee out quiet", 8'h00, got)
        for (i = 0; i < 2; i = i + 1) begin
            wb(0, 5'h14, 0);
            `CHK("ee in", 32'hC6 + i, q)
        end
        wb(1, 5'h00, 32'h27);
        wb(0, 5'h00, 0);
        `CHK("ee with sync fmt", 6'h25, q[5:0])
        wb(1, 5'h04, 32'h11);
        wb(1, 5'h00, 32'h5);
        wb(1, 5'h14, 32'h0);
        done;
        `CHK("overflow pin", 1'b1, ovf)
        wb(0, 5'h18, 0);
        `CHK("overflow status", 2'b11, q[5:4])
        wb(0, 5'h18, 0);
        `CHK("overflow cleared", 1'b0, q[5])
        for (i = 0; i < 16; i = i + 1) begin
            wb(0, 5'h14, 0);
            `CHK("kept frame", 32'hC3 + i, q)
        end
        wb(1, 5'h0C, 32'h0);
        wb(1, 5'h1C, 32'h301);
        wb(1, 5'h00, 32'h9);
        repeat (4) @(posedge clk_i);
        `CHK("thresh empty", 1'b1, thr)
        wb(1, 5'h00, 32'h8);
        wb(1, 5'h0C, 32'h1);
        repeat (4) @(posedge clk_i);
        `CHK("idle clock", 1'b1, sclk)
        wb(1, 5'h14, 32'h1);
        wb(1, 5'h14, 32'h2);
        repeat (40) @(posedge clk_i);
        `CHK("disabled busy", 1'b0, busy)
        `CHK("disabled ss", 4'hF, ss_n)
        wb(1, 5'h0C, 32'h0);
        wb(1, 5'h00, 32'h49);
        repeat (2) @(posedge clk_i);
        `CHK("thresh above", 1'b0, thr)
        `CHK("dma request", 1'b1, dreq)
        close_out;
    end
endmodule
